// File: rtl/dwp_pkg.sv
// package: shared constants, states and carriers of the dual wiper unit
package dwp_pkg;
	localparam int TAP_W = 5;
	localparam int TAP_N = 32;
	localparam logic [4:0] TAP_RESET = 5'h00;
	localparam logic [4:0] TAP_TOP = 5'h1F;
	localparam logic [3:0] OP_WRITE = 4'hA;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam int CMD_OP_HI = 7;
	localparam int CMD_OP_LO = 4;
	localparam int CMD_ZC_BIT = 2;
	localparam int CMD_RIGHT_BIT = 1;
	localparam int CMD_LEFT_BIT = 0;
	localparam int ADDR_TYPE_HI = 7;
	localparam int ADDR_TYPE_LO = 4;
	localparam int ADDR_ZERO_BIT = 3;
	localparam int ADDR_SEL_HI_BIT = 2;
	localparam int ADDR_SEL_LO_BIT = 1;
	localparam int ADDR_RW_BIT = 0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam int CH_LEFT = 0;
	localparam int CH_RIGHT = 1;
	localparam logic [2:0] SYNC_RESET = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_DATA,
		ST_READ,
		ST_STEP
	} dwp_state_e;

	// a wiper change waiting for the zero crossing
	typedef struct packed {
		logic pend;
		logic [4:0] val;
	} dwp_hold_s;
endpackage

// File: rtl/dwp_unit.sv
// dual wiper two-wire slave: command decoder and wiper position registers
`timescale 1ns/10ps
module dwp_unit import dwp_pkg::*; #(
	parameter logic [3:0] DEV_TYPE_ID = 4'hC, // arbitrary value
	parameter int POS_W = TAP_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_select_hi,
	input wire logic addr_select_lo,
	input wire logic zero_cross_det,
	output logic [4:0] left_wiper_position,
	output logic [4:0] right_wiper_position,
	output logic [31:0] left_tap_sel,
	output logic [31:0] right_tap_sel
);
	generate
		if (POS_W != TAP_W) begin : g_bad_width
			$error("dwp_unit: position width must be five");
		end
	endgenerate

	function automatic logic [31:0] onehot_tap(input logic [4:0] pos);
		onehot_tap = 32'h00000001 << pos;
	endfunction

	function automatic logic [4:0] step_tap(input logic [4:0] pos,
		input logic up);
		if (up) begin
			step_tap = (pos == TAP_TOP) ? TAP_TOP : pos + 5'h01;
		end else begin
			step_tap = (pos == TAP_RESET) ? TAP_RESET : pos - 5'h01;
		end
	endfunction

	// link domain: data bit captured at each rising clock edge
	logic bit_ff;
	always_ff @(posedge scl_clk) begin
		bit_ff <= sda_in;
	end

	// pin synchronisers; stage 0 feeds stage 1 only
	logic [2:0] scl_s_ff;
	logic [2:0] sda_s_ff;
	logic [1:0] bit_s_ff;
	logic [1:0] pin_hi_ff;
	logic [1:0] pin_lo_ff;
	logic [1:0] zc_s_ff;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			scl_s_ff <= SYNC_RESET;
			sda_s_ff <= SYNC_RESET;
			bit_s_ff <= 2'h0;
			pin_hi_ff <= 2'h0;
			pin_lo_ff <= 2'h0;
			zc_s_ff <= 2'h0;
		end else begin
			scl_s_ff <= {scl_s_ff[1:0], scl_clk};
			sda_s_ff <= {sda_s_ff[1:0], sda_in};
			bit_s_ff <= {bit_s_ff[0], bit_ff};
			pin_hi_ff <= {pin_hi_ff[0], addr_select_hi};
			pin_lo_ff <= {pin_lo_ff[0], addr_select_lo};
			zc_s_ff <= {zc_s_ff[0], zero_cross_det};
		end
	end

	wire scl_high = scl_s_ff[1] & scl_s_ff[2];
	wire fall_ev = scl_s_ff[2] & ~scl_s_ff[1];
	wire start_ev = scl_high & sda_s_ff[2] & ~sda_s_ff[1];
	wire stop_ev = scl_high & ~sda_s_ff[2] & sda_s_ff[1];
	// bit sampled by the link clock has settled long before the fall
	wire rx_bit = bit_s_ff[1];
	wire zc_now = zc_s_ff[1];

	dwp_state_e st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] sh_ff, nxt_sh;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] cmd_ff, nxt_cmd;
	logic ack_ff, nxt_ack;
	logic drv_ff, nxt_drv;
	logic rd_ff, nxt_rd;
	logic dsel_ff, nxt_dsel;
	logic [4:0] pos_ff [2];
	dwp_hold_s hold_ff [2];

	wire [7:0] rx_byte = {sh_ff[6:0], rx_bit};
	wire receiving = (st_ff == ST_ADDR) | (st_ff == ST_CMD) |
		(st_ff == ST_DATA);
	wire byte_done = fall_ev & receiving & ~ack_ff & (cnt_ff == BIT_LAST);
	wire ack_end = fall_ev & ack_ff;

	wire addr_match = (rx_byte[ADDR_TYPE_HI:ADDR_TYPE_LO] == DEV_TYPE_ID) &
		~rx_byte[ADDR_ZERO_BIT] &
		(rx_byte[ADDR_SEL_HI_BIT] == pin_hi_ff[1]) &
		(rx_byte[ADDR_SEL_LO_BIT] == pin_lo_ff[1]);
	wire [3:0] rx_op = rx_byte[CMD_OP_HI:CMD_OP_LO];
	wire cmd_ok = ((rx_op == OP_WRITE) | (rx_op == OP_STEP)) &
		(rx_byte[CMD_LEFT_BIT] | rx_byte[CMD_RIGHT_BIT]);
	wire byte_ok = (st_ff == ST_ADDR) ? addr_match :
		(st_ff == ST_CMD) ? cmd_ok : 1'b1;

	wire sel_l = cmd_ff[CMD_LEFT_BIT];
	wire sel_r = cmd_ff[CMD_RIGHT_BIT];
	wire both_sel = sel_l & sel_r;
	wire zc_en = cmd_ff[CMD_ZC_BIT];
	wire data_done = byte_done & (st_ff == ST_DATA);
	wire step_ev = fall_ev & (st_ff == ST_STEP);

	// write and step requests per wiper
	logic [1:0] wr_req;
	logic [1:0] step_req;
	assign wr_req[CH_LEFT] = data_done & sel_l & (~sel_r | ~dsel_ff);
	assign wr_req[CH_RIGHT] = data_done & sel_r & (~sel_l | dsel_ff);
	assign step_req[CH_LEFT] = step_ev & sel_l;
	assign step_req[CH_RIGHT] = step_ev & sel_r;

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_cmd = cmd_ff;
		nxt_ack = ack_ff;
		nxt_drv = drv_ff;
		nxt_rd = rd_ff;
		nxt_dsel = dsel_ff;
		if (start_ev) begin
			nxt_st = ST_ADDR;
			nxt_cnt = 4'hF; // first fall belongs to the start
			nxt_ack = 1'b0;
			nxt_drv = 1'b0;
			nxt_dsel = 1'b0;
		end else if (stop_ev) begin
			nxt_st = ST_IDLE;
			nxt_ack = 1'b0;
			nxt_drv = 1'b0;
		end else if (ack_end) begin
			// ninth clock over: release and move on
			nxt_ack = 1'b0;
			nxt_drv = 1'b0;
			nxt_cnt = 4'h0;
			case (st_ff)
				ST_ADDR: begin
					if (sh_ff[ADDR_RW_BIT]) begin
						nxt_st = ST_READ;
						nxt_tx = {3'h0, pos_ff[CH_LEFT]};
						nxt_drv = 1'b1;
						nxt_rd = 1'b0;
					end else begin
						nxt_st = ST_CMD;
					end
				end
				ST_CMD: begin
					nxt_st = (cmd_ff[CMD_OP_HI:CMD_OP_LO] == OP_WRITE) ?
						ST_DATA : ST_STEP;
				end
				ST_DATA: begin
					if (both_sel & ~dsel_ff) begin
						nxt_dsel = 1'b1;
					end else begin
						nxt_st = ST_IDLE;
					end
				end
				default: nxt_st = ST_IDLE;
			endcase
		end else if (byte_done) begin
			nxt_sh = rx_byte;
			nxt_cnt = BIT_ACK;
			if (byte_ok) begin
				nxt_ack = 1'b1;
				nxt_drv = 1'b1;
				if (st_ff == ST_CMD) begin
					nxt_cmd = rx_byte;
				end
			end else begin
				nxt_st = ST_IDLE;
			end
		end else if (fall_ev & receiving) begin
			nxt_sh = rx_byte;
			nxt_cnt = cnt_ff + 4'h1;
		end else if (fall_ev & (st_ff == ST_READ)) begin
			if (cnt_ff < BIT_LAST) begin
				nxt_tx = {tx_ff[6:0], 1'b0};
				nxt_drv = ~tx_ff[6];
				nxt_cnt = cnt_ff + 4'h1;
			end else if (cnt_ff == BIT_LAST) begin
				nxt_drv = 1'b0;
				nxt_cnt = BIT_ACK;
			end else if (~rx_bit & ~rd_ff) begin
				// master took the left byte; right follows
				nxt_tx = {3'h0, pos_ff[CH_RIGHT]};
				nxt_drv = 1'b1;
				nxt_rd = 1'b1;
				nxt_cnt = 4'h0;
			end else begin
				nxt_st = ST_IDLE;
				nxt_drv = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			cmd_ff <= 8'h00;
			ack_ff <= 1'b0;
			drv_ff <= 1'b0;
			rd_ff <= 1'b0;
			dsel_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			cmd_ff <= nxt_cmd;
			ack_ff <= nxt_ack;
			drv_ff <= nxt_drv;
			rd_ff <= nxt_rd;
			dsel_ff <= nxt_dsel;
		end
	end

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = drv_ff;

	// per wiper position, deferral and tap decode
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_chan
			logic [4:0] base;
			logic [4:0] target;
			logic req;
			logic [31:0] tap_ff;
			assign base = hold_ff[c].pend ? hold_ff[c].val : pos_ff[c];
			assign req = wr_req[c] | step_req[c];
			assign target = wr_req[c] ? rx_byte[4:0] :
				step_tap(base, rx_bit);
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					pos_ff[c] <= TAP_RESET;
					hold_ff[c] <= '0;
					tap_ff <= 32'h00000001;
				end else if (req & zc_en) begin
					hold_ff[c] <= '{pend: 1'b1, val: target};
				end else if (req) begin
					pos_ff[c] <= target;
					hold_ff[c].pend <= 1'b0;
					tap_ff <= onehot_tap(target);
				end else if (hold_ff[c].pend & zc_now) begin
					pos_ff[c] <= hold_ff[c].val;
					hold_ff[c].pend <= 1'b0;
					tap_ff <= onehot_tap(hold_ff[c].val);
				end
			end
		end
	endgenerate

	assign left_wiper_position = pos_ff[CH_LEFT];
	assign right_wiper_position = pos_ff[CH_RIGHT];
	assign left_tap_sel = g_chan[0].tap_ff;
	assign right_tap_sel = g_chan[1].tap_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_ack_release;
		ack_end && st_ff != ST_ADDR |=> !sda_oe;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("acknowledge not released after ninth clock");
	property p_addr_ack;
		byte_done && st_ff == ST_ADDR && addr_match |=> ack_ff && sda_oe;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address not acknowledged");
	property p_addr_nack;
		byte_done && st_ff == ST_ADDR && !addr_match
			|=> st_ff == ST_IDLE && !sda_oe;
	endproperty
	a_addr_nack: assert property (p_addr_nack)
		else $error("foreign address acknowledged");
	property p_cmd_bad;
		byte_done && st_ff == ST_CMD && !cmd_ok |=> st_ff == ST_IDLE && !ack_ff;
	endproperty
	a_cmd_bad: assert property (p_cmd_bad)
		else $error("invalid command acknowledged");
	property p_read_entry;
		ack_end && st_ff == ST_ADDR && sh_ff[ADDR_RW_BIT]
			|=> st_ff == ST_READ && tx_ff == {3'h0, left_wiper_position};
	endproperty
	a_read_entry: assert property (p_read_entry)
		else $error("read did not start with left wiper byte");
	property p_write_now;
		wr_req[CH_LEFT] && !zc_en
			|=> left_wiper_position == $past(rx_byte[4:0]) ##1
			left_tap_sel == onehot_tap($past(rx_byte[4:0], 2));
	endproperty
	a_write_now: assert property (p_write_now)
		else $error("left wiper not loaded directly");
	property p_defer;
		wr_req[CH_LEFT] && zc_en && !zc_now
			|=> $stable(left_wiper_position) && hold_ff[CH_LEFT].pend;
	endproperty
	a_defer: assert property (p_defer)
		else $error("deferred change applied early");
	property p_step_up;
		step_req[CH_RIGHT] && rx_bit && !zc_en && !hold_ff[CH_RIGHT].pend
			&& right_wiper_position != TAP_TOP
			|=> right_wiper_position == $past(right_wiper_position) + 5'h01;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("step up did not advance one tap");
	property p_step_down;
		step_req[CH_RIGHT] && !rx_bit && !zc_en && !hold_ff[CH_RIGHT].pend
			&& right_wiper_position != TAP_RESET
			|=> right_wiper_position == $past(right_wiper_position) - 5'h01;
	endproperty
	a_step_down: assert property (p_step_down)
		else $error("step down did not retreat one tap");
	property p_saturate;
		step_req[CH_RIGHT] && rx_bit && !zc_en && !hold_ff[CH_RIGHT].pend
			&& right_wiper_position == TAP_TOP
			|=> right_wiper_position == TAP_TOP;
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("wiper wrapped past top tap");
	property p_onehot;
		$onehot(left_tap_sel) && $onehot(right_tap_sel);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("tap select not one-hot");
	property p_stop_idle;
		stop_ev && !start_ev |=> st_ff == ST_IDLE && !sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not return to idle");
	c_read: cover property (fall_ev && st_ff == ST_READ && rd_ff &&
		cnt_ff == BIT_ACK);
	c_write_both: cover property (wr_req[CH_RIGHT] && both_sel);
	c_step: cover property (step_req[CH_LEFT] && step_req[CH_RIGHT]);
	c_zero_cross: cover property (hold_ff[CH_LEFT].pend && zc_now);
endmodule

// File: testbench/dwp_mst.sv
// two-wire bus master model: drives serial clock and pulls the data line
`timescale 1ns/10ps
module dwp_mst (
	output logic scl_clk,
	output logic sda_low,
	input wire logic sda_in
);
	// idle bus: clock stands high, data released to the pull-up
	initial begin
		scl_clk = 1'h1;
		sda_low = 1'h0;
	end
	// also serves as repeated start when the clock is low
	task automatic start();
		#20 sda_low = 1'h0;
		#40 scl_clk = 1'h1;
		#60 sda_low = 1'h1;
		#60 scl_clk = 1'h0;
	endtask
	task automatic stop();
		#20 sda_low = 1'h1;
		#40 scl_clk = 1'h1;
		#60 sda_low = 1'h0;
		#60;
	endtask
	// data changes only while clock is low; sampled late in the high
	// phase because the device answers up to 75 ns after a fall
	task automatic bit_io(input logic b, output logic r);
		#20 sda_low = !b;
		#80 scl_clk = 1'h1;
		#55 r = sda_in;
		#5 scl_clk = 1'h0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic nine,
		output logic [7:0] q, output logic r9);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nine, r9);
	endtask
endmodule

// File: testbench/dwp_unit_tb_top.sv
// self-checking bench for the dual wiper two-wire command unit
`timescale 1ns/10ps
module dwp_unit_tb_top;
	import dwp_pkg::*;
	localparam logic [3:0] TYPE_ID = 4'h9; // arbitrary value
	logic ref_clk, rstn, scl_clk, sda_low, sda_out, sda_oe;
	logic sel_hi, sel_lo, zc, a;
	logic [4:0] lpos, rpos;
	logic [31:0] ltap, rtap;
	logic [7:0] q;
	wire logic sda;
	int miscompares, num_checks;
	// open drain: low if any party pulls, else the pull-up wins
	assign sda = !((sda_oe && !sda_out) || sda_low);
	dwp_unit #(.DEV_TYPE_ID(TYPE_ID)) i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .scl_clk(scl_clk),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_select_hi(sel_hi), .addr_select_lo(sel_lo),
		.zero_cross_det(zc), .left_wiper_position(lpos),
		.right_wiper_position(rpos), .left_tap_sel(ltap),
		.right_tap_sel(rtap)
	);
	dwp_mst i_mst (.scl_clk(scl_clk), .sda_low(sda_low), .sda_in(sda));
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] adr(input logic rw);
		return {TYPE_ID, 1'h0, 2'h2, rw};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic ack);
		logic r;
		i_mst.xfer(d, 1'h1, q, r);
		chk("ack", {31'h0, ack}, {31'h0, !r});
	endtask
	task automatic pos(input logic [4:0] l, input logic [4:0] r);
		repeat (10) @(posedge ref_clk);
		chk("left", {27'h0, l}, {27'h0, lpos});
		chk("right", {27'h0, r}, {27'h0, rpos});
		chk("left tap", 32'h1 << l, ltap);
		chk("right tap", 32'h1 << r, rtap);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d0,
		input logic [7:0] d1, input int n);
		i_mst.start();
		send(adr(1'h0), 1'h1);
		send(c, 1'h1);
		if (n > 0) send(d0, 1'h1);
		if (n > 1) send(d1, 1'h1);
		i_mst.stop();
	endtask
	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	initial begin
		rstn = 1'h0;
		sel_hi = 1'h1;
		sel_lo = 1'h0;
		zc = 1'h0;
		miscompares = 0;
		num_checks = 0;
		repeat (10) @(posedge ref_clk);
		#1 rstn = 1'h1;
		repeat (6) @(posedge ref_clk);
		pos(5'h00, 5'h00);
		tend("reset");
		// upper three data bits must be ignored
		wr(8'hA1, 8'hF5, 8'h00, 1);
		pos(5'h15, 5'h00);
		tend("write left");
		wr(8'hA3, 8'h0A, 8'h1C, 2);
		pos(5'h0A, 5'h1C);
		tend("write both");
		i_mst.start();
		send(adr(1'h1), 1'h1);
		i_mst.xfer(8'hFF, 1'h0, q, a);
		chk("left read", 32'h0A, {24'h0, q});
		i_mst.xfer(8'hFF, 1'h1, q, a);
		chk("right read", 32'h1C, {24'h0, q});
		i_mst.stop();
		tend("read");
		i_mst.start();
		send({TYPE_ID, 1'h0, 2'h1, 1'h0}, 1'h0);
		i_mst.start();
		send(adr(1'h0) | 8'h08, 1'h0);
		i_mst.start();
		send(adr(1'h0), 1'h1);
		send(8'h53, 1'h0);
		send(8'h03, 1'h0);
		i_mst.start();
		send(adr(1'h0), 1'h1);
		send(8'hA0, 1'h0);
		i_mst.stop();
		pos(5'h0A, 5'h1C);
		tend("refused");
		i_mst.start();
		send(adr(1'h0), 1'h1);
		send(8'h22, 1'h1);
		repeat (4) i_mst.bit_io(1'h1, a);
		i_mst.bit_io(1'h0, a);
		i_mst.stop();
		pos(5'h0A, 5'h1E);
		i_mst.start();
		send(adr(1'h0), 1'h1);
		send(8'h23, 1'h1);
		repeat (12) i_mst.bit_io(1'h0, a);
		i_mst.stop();
		pos(5'h00, 5'h12);
		tend("step");
		wr(8'hA5, 8'h07, 8'h00, 1);
		pos(5'h00, 5'h12);
		@(posedge ref_clk);
		#1 zc = 1'h1;
		pos(5'h07, 5'h12);
		tend("zero crossing");
		final_report();
	end
endmodule
